// ---- rtl/in_fifo_slots.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "usb_in_ep_defs.svh"

module in_fifo_slots (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic pop,
  output usb_in_ep_pkg::slot_cnt_t slot_cnt,
  output logic not_empty
);

  usb_in_ep_pkg::slot_cnt_t cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= usb_in_ep_pkg::slot_next(cnt_q, push, pop);
    end
  end

  assign slot_cnt = cnt_q;
  assign not_empty = (cnt_q != 2'h0);

endmodule

`default_nettype wire

// ---- rtl/usb_in_endpoint_fifo_status.sv ----
// Functional notes
// - Writing one to the purge bit drops the next queued IN packet, resets the pointer and clears packet ready.
// - The purge bit returns to zero by itself when the drop has finished.
// - In isochronous mode a zero-length answer to an IN token sets the underrun flag.
// - In bulk or interrupt mode a NAK answer to an IN token sets the underrun flag.
// - The not-empty flag reads one while the IN FIFO holds at least one packet, else zero.
// - Packet ready clears on transmission, or when double buffering is on and a slot is free.
// - With isochronous mode and the update setting on, packet ready reads zero until the next SOF.
// - A transmission that clears packet ready raises the IN interrupt when it is enabled.
// - Double-buffer enable gives the FIFO two packet slots, otherwise one.
// - The isochronous enable picks isochronous handling at one and bulk or interrupt at zero.
`timescale 1ns/1ps
`default_nettype none
`include "usb_in_ep_defs.svh"

module usb_in_endpoint_fifo_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`IN_EP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_token,
  input wire logic sof_rx,
  output usb_in_ep_pkg::usb_in_resp_s tx_resp,
  output logic fifo_ptr_reset,
  output logic irq
);

  logic purge_q;
  logic underrun_q;
  logic ready_q;
  logic hold_q;
  logic dbl_q;
  logic iso_q;
  logic isochronous_update_q;
  logic [`IN_EP_INT_W-1:0] sts_q;
  logic [`IN_EP_INT_W-1:0] sts_d;
  logic [`IN_EP_INT_W-1:0] en_q;
  logic [31:0] rdata_d;
  logic addr_ok;
  logic wr_en;
  logic ctrl_wr;
  logic push;
  logic pop;
  logic tok_data;
  logic tok_empty;
  logic fifo_ne;
  logic ready_rd;
  usb_in_ep_pkg::slot_cnt_t slot_cnt;
  usb_in_ep_pkg::slot_cnt_t cnt_next;
  usb_in_ep_pkg::slot_cnt_t cap;

  // Bus decode: no wait states, the access phase completes on its first cycle.
  assign wr_en = psel && penable && pready && pwrite;
  assign ctrl_wr = wr_en && (paddr == `IN_EP_CTRL_OFF);
  assign addr_ok = (paddr == `IN_EP_CTRL_OFF) || (paddr == `IN_EP_CFG_OFF) ||
                   (paddr == `IN_EP_INT_STS_OFF) || (paddr == `IN_EP_INT_CLR_OFF) ||
                   (paddr == `IN_EP_INT_EN_OFF);

  assign cap = dbl_q ? `IN_EP_SLOTS_DOUBLE : `IN_EP_SLOTS_SINGLE;
  assign ready_rd = ready_q && !hold_q;

  // A packet is committed when software raises packet ready and a slot is free.
  assign push = ctrl_wr && pwdata[`IN_EP_READY_BIT] && !ready_q && (slot_cnt < cap);
  assign tok_data = in_token && !purge_q && fifo_ne && !hold_q;
  assign tok_empty = in_token && !tok_data;
  assign pop = (purge_q && fifo_ne) || tok_data;
  assign cnt_next = usb_in_ep_pkg::slot_next(slot_cnt, push, pop);

  in_fifo_slots u_slots (
    .pclk(pclk),
    .presetn(presetn),
    .push(push),
    .pop(pop),
    .slot_cnt(slot_cnt),
    .not_empty(fifo_ne)
  );

  always_comb begin
    rdata_d = 32'h0;
    unique case (paddr)
      `IN_EP_CTRL_OFF: begin
        rdata_d[`IN_EP_PURGE_BIT] = purge_q;
        rdata_d[`IN_EP_UNDERRUN_BIT] = underrun_q;
        rdata_d[`IN_EP_NOT_EMPTY_BIT] = fifo_ne;
        rdata_d[`IN_EP_READY_BIT] = ready_rd;
      end
      `IN_EP_CFG_OFF: begin
        rdata_d[`IN_EP_DBL_BIT] = dbl_q;
        rdata_d[`IN_EP_ISO_BIT] = iso_q;
        rdata_d[`IN_EP_ISO_UPDATE_BIT] = isochronous_update_q;
      end
      `IN_EP_INT_STS_OFF: rdata_d[`IN_EP_INT_W-1:0] = sts_q;
      `IN_EP_INT_EN_OFF: rdata_d[`IN_EP_INT_W-1:0] = en_q;
      default: rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= !addr_ok;
        prdata <= pwrite ? 32'h0 : rdata_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbl_q <= 1'b0;
      iso_q <= 1'b0;
      isochronous_update_q <= 1'b0;
      en_q <= `IN_EP_INT_EN_RESET;
    end else begin
      if (wr_en && (paddr == `IN_EP_CFG_OFF)) begin
        dbl_q <= pwdata[`IN_EP_DBL_BIT];
        iso_q <= pwdata[`IN_EP_ISO_BIT];
        isochronous_update_q <= pwdata[`IN_EP_ISO_UPDATE_BIT];
      end
      if (wr_en && (paddr == `IN_EP_INT_EN_OFF)) begin
        en_q <= pwdata[`IN_EP_INT_W-1:0];
      end
    end
  end

  // Purge is write-one only and clears itself after the one-cycle drop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      purge_q <= 1'b0;
      fifo_ptr_reset <= 1'b0;
    end else begin
      fifo_ptr_reset <= purge_q;
      if (purge_q) begin
        purge_q <= 1'b0;
      end else if (ctrl_wr && pwdata[`IN_EP_PURGE_BIT]) begin
        purge_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
    end else if (purge_q) begin
      ready_q <= 1'b0;
    end else if (tok_data || (dbl_q && (cnt_next < `IN_EP_SLOTS_DOUBLE))) begin
      ready_q <= 1'b0;
    end else if (push) begin
      ready_q <= 1'b1;
    end
  end

  // Hold marks a packet committed under isochronous update; SOF releases it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'b0;
    end else if (push && iso_q && isochronous_update_q) begin
      hold_q <= 1'b1;
    end else if (sof_rx || purge_q) begin
      hold_q <= 1'b0;
    end
  end

  // Hardware sets, software clears by writing zero; a set in the same cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      underrun_q <= 1'b0;
    end else if (tok_empty) begin
      underrun_q <= 1'b1;
    end else if (ctrl_wr && !pwdata[`IN_EP_UNDERRUN_BIT]) begin
      underrun_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_resp <= '0;
    end else begin
      tx_resp.send_data <= tok_data;
      tx_resp.send_zlp <= tok_empty && iso_q;
      tx_resp.send_nak <= tok_empty && !iso_q;
    end
  end

  always_comb begin
    sts_d = sts_q;
    if (wr_en && (paddr == `IN_EP_INT_CLR_OFF)) begin
      sts_d = sts_d & ~pwdata[`IN_EP_INT_W-1:0];
    end
    sts_d[`IN_EP_INT_TX_BIT] = sts_d[`IN_EP_INT_TX_BIT] | tok_data;
    sts_d[`IN_EP_INT_UNDERRUN_BIT] = sts_d[`IN_EP_INT_UNDERRUN_BIT] | tok_empty;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q <= '0;
      irq <= 1'b0;
    end else begin
      sts_q <= sts_d;
      irq <= |(sts_d & en_q);
    end
  end

  AST_PURGE_SELF_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    purge_q |=> !purge_q && !ready_q && fifo_ptr_reset)
    else $error("purge did not finish in one cycle");

  AST_PURGE_DROPS_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    purge_q && fifo_ne && !push |=> slot_cnt == $past(slot_cnt) - 2'h1)
    else $error("purge did not drop exactly one packet");

  AST_ISO_ZLP_UNDERRUN: assert property (@(posedge pclk) disable iff (!presetn)
    in_token && iso_q && !tok_data |=> tx_resp.send_zlp && !tx_resp.send_data && underrun_q)
    else $error("isochronous empty token not answered by zero-length packet");

  AST_NAK_UNDERRUN: assert property (@(posedge pclk) disable iff (!presetn)
    in_token && !iso_q && !tok_data |=> tx_resp.send_nak && !tx_resp.send_zlp && underrun_q)
    else $error("bulk empty token not answered by NAK");

  AST_NOT_EMPTY_READ: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && (paddr == `IN_EP_CTRL_OFF)
    |=> prdata[`IN_EP_NOT_EMPTY_BIT] == ($past(slot_cnt) != 2'h0))
    else $error("not-empty flag disagrees with packet count");

  AST_TX_CLEARS_READY: assert property (@(posedge pclk) disable iff (!presetn)
    tok_data && ready_q |=> !ready_q && tx_resp.send_data)
    else $error("packet ready not cleared after transmission");

  AST_DBL_OPEN_SLOT: assert property (@(posedge pclk) disable iff (!presetn)
    ready_q && dbl_q && $stable(dbl_q) && !purge_q |-> slot_cnt == `IN_EP_SLOTS_DOUBLE)
    else $error("packet ready held with a free double-buffer slot");

  AST_ISO_HOLD_READ: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && (paddr == `IN_EP_CTRL_OFF) && hold_q
    |=> !prdata[`IN_EP_READY_BIT])
    else $error("packet ready visible before SOF");

  AST_TX_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    tok_data && en_q[`IN_EP_INT_TX_BIT] |=> sts_q[`IN_EP_INT_TX_BIT] && irq)
    else $error("transmission did not raise the interrupt");

  AST_ZERO_PURGE_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr && !pwdata[`IN_EP_PURGE_BIT] && !purge_q |=> !purge_q && !fifo_ptr_reset)
    else $error("writing zero to purge started a purge");

  AST_PURGE_STARTS: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr && pwdata[`IN_EP_PURGE_BIT] && !purge_q |=> purge_q)
    else $error("writing one to purge did not start a purge");

  AST_TOKEN_ONE_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
    in_token |=> $onehot(tx_resp))
    else $error("IN token not answered by exactly one response");

  AST_RESP_EXCLUSIVE: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(tx_resp))
    else $error("more than one token response at once");

  AST_PUSH_NOT_EMPTY: assert property (@(posedge pclk) disable iff (!presetn)
    push |=> fifo_ne)
    else $error("committed packet not reported as queued");

  AST_UNDERRUN_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    underrun_q && !ctrl_wr |=> underrun_q)
    else $error("underrun flag cleared without a software write");

  AST_SLOT_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
    slot_cnt != 2'h3)
    else $error("packet count above two slots");

  AST_SOF_RELEASES_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    sof_rx && !push |=> !hold_q)
    else $error("start of frame did not release the held packet");

  AST_HOLD_BLOCKS_DATA: assert property (@(posedge pclk) disable iff (!presetn)
    hold_q && in_token |=> !tx_resp.send_data)
    else $error("held packet sent before start of frame");

  AST_READY_HAS_PACKET: assert property (@(posedge pclk) disable iff (!presetn)
    ready_q |-> fifo_ne)
    else $error("packet ready set with an empty FIFO");

  AST_IRQ_NEEDS_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> |sts_q)
    else $error("interrupt raised with no status bit set");

  COV_DOUBLE_FULL: cover property (@(posedge pclk) disable iff (!presetn)
    dbl_q && slot_cnt == `IN_EP_SLOTS_DOUBLE);
  COV_ISO_SOF_RELEASE: cover property (@(posedge pclk) disable iff (!presetn)
    hold_q ##1 sof_rx ##[1:4] tok_data);
  COV_UNDERRUN_NAK: cover property (@(posedge pclk) disable iff (!presetn)
    tok_empty && !iso_q);
  COV_PURGE_FULL: cover property (@(posedge pclk) disable iff (!presetn)
    purge_q && slot_cnt == `IN_EP_SLOTS_DOUBLE);

endmodule

`default_nettype wire

// ---- rtl/usb_in_ep_defs.svh ----
`ifndef USB_IN_EP_DEFS_SVH
`define USB_IN_EP_DEFS_SVH

`define IN_EP_ADDR_W 8
`define IN_EP_CTRL_OFF 8'h00
`define IN_EP_CFG_OFF 8'h04
`define IN_EP_INT_STS_OFF 8'h08
`define IN_EP_INT_CLR_OFF 8'h0c
`define IN_EP_INT_EN_OFF 8'h10

`define IN_EP_READY_BIT 0
`define IN_EP_NOT_EMPTY_BIT 1
`define IN_EP_UNDERRUN_BIT 2
`define IN_EP_PURGE_BIT 3

`define IN_EP_ISO_UPDATE_BIT 0
`define IN_EP_ISO_BIT 6
`define IN_EP_DBL_BIT 7

`define IN_EP_INT_TX_BIT 0
`define IN_EP_INT_UNDERRUN_BIT 1
`define IN_EP_INT_W 2

`define IN_EP_SLOTS_SINGLE 2'h1
`define IN_EP_SLOTS_DOUBLE 2'h2
`define IN_EP_CFG_RESET 8'h00
`define IN_EP_INT_EN_RESET 2'h0

`endif

// ---- rtl/usb_in_ep_pkg.sv ----
package usb_in_ep_pkg;

  typedef logic [1:0] slot_cnt_t;

  // Answer given to one IN token; at most one field is high at a time.
  typedef struct packed {
    logic send_data;
    logic send_zlp;
    logic send_nak;
  } usb_in_resp_s;

  function automatic slot_cnt_t slot_next(input slot_cnt_t cnt, input logic push,
                                          input logic pop);
    slot_cnt_t n;
    n = cnt;
    if (push && !pop) begin
      n = cnt + 2'h1;
    end else if (pop && !push) begin
      n = cnt - 2'h1;
    end
    return n;
  endfunction

endpackage

// ---- tb/usb_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  input wire logic pclk,
  input wire usb_in_ep_pkg::usb_in_resp_s tx_resp,
  output logic in_token,
  output logic sof_rx
);
  initial begin
    in_token = 1'b0;
    sof_rx = 1'b0;
  end
  // The answer stands for one cycle only, so it is taken mid-cycle after the token edge.
  task automatic token(output usb_in_ep_pkg::usb_in_resp_s resp);
    @(posedge pclk);
    in_token <= 1'b1;
    @(posedge pclk);
    in_token <= 1'b0;
    @(negedge pclk);
    resp = tx_resp;
  endtask
  task automatic frame();
    @(posedge pclk);
    sof_rx <= 1'b1;
    @(posedge pclk);
    sof_rx <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/usb_in_endpoint_fifo_status_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "usb_in_ep_defs.svh"
`define CHK(nm, exp, got) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module usb_in_endpoint_fifo_status_tb;
  localparam logic [2:0] r_data = 3'h4;
  localparam logic [2:0] r_zlp = 3'h2;
  localparam logic [2:0] r_nak = 3'h1;
  localparam logic [7:0] ctl = `IN_EP_CTRL_OFF;
  localparam logic [7:0] cfg = `IN_EP_CFG_OFF;
  localparam logic [7:0] clr = `IN_EP_INT_CLR_OFF;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`IN_EP_ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, in_token, sof_rx, fifo_ptr_reset, irq;
  usb_in_ep_pkg::usb_in_resp_s tx_resp;
  int bad_count = 0;
  int total_checks = 0;
  int ptr_resets = 0;
  always #4 pclk = ~pclk;
  always @(posedge pclk) if (fifo_ptr_reset === 1'b1) ptr_resets++;
  usb_in_endpoint_fifo_status dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_token(in_token), .sof_rx(sof_rx),
    .tx_resp(tx_resp), .fifo_ptr_reset(fifo_ptr_reset), .irq(irq));
  usb_host_model host_u (.pclk(pclk), .tx_resp(tx_resp), .in_token(in_token),
    .sof_rx(sof_rx));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK(nm, exp, q)
  endtask
  task automatic tok(input logic [2:0] exp);
    usb_in_ep_pkg::usb_in_resp_s r;
    host_u.token(r);
    `CHK("tx_resp", exp, r)
  endtask
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rd("ctrl", ctl, 32'h0);
    rd("cfg", cfg, 32'h0);
    apb(1'b0, 8'h20, 32'h0, q, e);
    `CHK("pslverr", 1'b1, e)
    `CHK("irq", 1'b0, irq)
    $display("reset test done");
  endtask
  task automatic t_bulk();
    wr(`IN_EP_INT_EN_OFF, 32'h1);
    rd("int_en", `IN_EP_INT_EN_OFF, 32'h1);
    wr(ctl, 32'h1);
    rd("ctrl", ctl, 32'h3);
    tok(r_data);
    `CHK("irq", 1'b1, irq)
    rd("ctrl", ctl, 32'h0);
    tok(r_nak);
    rd("ctrl", ctl, 32'h4);
    wr(ctl, 32'h6);
    rd("ctrl", ctl, 32'h4);
    rd("int_sts", `IN_EP_INT_STS_OFF, 32'h3);
    wr(clr, 32'h1);
    @(negedge pclk);
    `CHK("irq", 1'b0, irq)
    wr(ctl, 32'h0);
    wr(clr, 32'h3);
    rd("ctrl", ctl, 32'h0);
    $display("bulk test done");
  endtask
  task automatic t_double();
    int n0;
    wr(cfg, 32'h80);
    wr(ctl, 32'h1);
    rd("ctrl", ctl, 32'h2);
    wr(ctl, 32'h1);
    rd("ctrl", ctl, 32'h3);
    n0 = ptr_resets;
    wr(ctl, 32'h8);
    rd("ctrl", ctl, 32'h2);
    `CHK("ptr_reset", n0 + 1, ptr_resets)
    wr(ctl, 32'h0);
    rd("ctrl", ctl, 32'h2);
    tok(r_data);
    rd("ctrl", ctl, 32'h0);
    wr(clr, 32'h3);
    $display("double buffer test done");
  endtask
  task automatic t_iso();
    wr(cfg, 32'h41);
    tok(r_zlp);
    rd("ctrl", ctl, 32'h4);
    wr(ctl, 32'h1);
    rd("ctrl", ctl, 32'h2);
    tok(r_zlp);
    host_u.frame();
    tok(r_data);
    rd("ctrl", ctl, 32'h4);
    $display("iso test done");
  endtask
  task automatic t_midreset();
    wr(cfg, 32'h0);
    wr(ctl, 32'h5);
    rd("ctrl", ctl, 32'h7);
    wr(ctl, 32'hc);
    rd("ctrl", ctl, 32'h4);
    wr(ctl, 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK("irq", 1'b0, irq)
    `CHK("tx_resp", 3'h0, tx_resp)
    @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl", ctl, 32'h0);
    rd("cfg", cfg, 32'h0);
    rd("int_sts", `IN_EP_INT_STS_OFF, 32'h0);
    $display("mid-run reset test done");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_bulk();
    t_double();
    t_iso();
    t_midreset();
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
